// *** pbd_pkg.sv ***
package pbd_pkg;

  // ---------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------
  localparam int CFG_WORDS = 8;
  localparam int CFG_AW = 3;
  localparam int CFG_W = 16;
  localparam int DW = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int ROUTE_N = 6;
  localparam int CTRL_W = 8;

  // ---------------------------------------------------------------------
  // configuration word field positions
  // ---------------------------------------------------------------------
  localparam int F_FUNC_LO = 0;   // [2:0] alu function
  localparam int F_SRCA = 3;      // a operand: 0 acc0, 1 acc1
  localparam int F_SRCB_LO = 4;   // [5:4] b operand: d0,d1,acc0,acc1
  localparam int F_SHIFT_LO = 6;  // [7:6] shift select
  localparam int F_CI_LO = 8;     // [9:8] carry-in select
  localparam int F_DST_LO = 10;   // [11:10] write acc0/acc1/both/none
  localparam int F_CRC = 12;      // crc/prs step instead of alu
  localparam int F_D0LD = 13;     // load d0 from input fifo0
  localparam int F_D1LD = 14;     // load d1 from input fifo1
  localparam int F_FWR = 15;      // push result into output fifo0 and acc1 into output fifo1

  typedef enum logic [2:0] {
    PBD_INC, PBD_DEC, PBD_ADD, PBD_SUB, PBD_AND, PBD_OR, PBD_XOR, PBD_PASS
  } pbd_func_e;

  typedef enum logic [1:0] {
    PBD_SH_NONE, PBD_SH_LEFT, PBD_SH_RIGHT, PBD_SH_SWAP
  } pbd_shift_e;

  // carry/shift-in source for time multiplexing and chaining
  localparam logic [1:0] CI_ZERO = 2'h0;
  localparam logic [1:0] CI_ONE = 2'h1;
  localparam logic [1:0] CI_CHAIN = 2'h2;
  localparam logic [1:0] CI_REG = 2'h3;

  // condition vector indices for the output select
  localparam int C_CE0 = 0;
  localparam int C_CL0 = 1;
  localparam int C_CE1 = 2;
  localparam int C_CL1 = 3;
  localparam int C_Z0 = 4;
  localparam int C_Z1 = 5;
  localparam int C_FF0 = 6;
  localparam int C_FF1 = 7;
  localparam int C_OV = 8;
  localparam int C_SO = 9;
  localparam int C_F0E = 10;
  localparam int C_F0F = 11;
  localparam int C_F1E = 12;
  localparam int C_F1F = 13;
  localparam int C_CO = 14;
  localparam int C_SOR = 15;
  localparam int COND_N = 16;
  localparam int COND_SW = 4;

  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] ONES = 8'hff;

  // chaining signals passed between neighbouring slices
  typedef struct packed {
    logic carry;
    logic shift;
    logic ce;
    logic cl;
    logic zero;
    logic ones;
  } pbd_chain_s;

  // fifo status
  typedef struct packed {
    logic empty;
    logic full;
  } pbd_fstat_s;

endpackage

// *** pbd_fifo.sv ***
`timescale 1ns/1ps
// small byte fifo with valid/ready on both sides
module pbd_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // status
  output logic empty,
  output logic full
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // refusing pushes when full and pops when empty protects entries
  assign full = (cnt_q == (AW+1)'(DEPTH));
  assign empty = (cnt_q == '0);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rp_q];
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;

  // pointer wrap assumes a power-of-two depth
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** pbd_datapath.sv ***
`timescale 1ns/1ps
// Overview of operation
// - eight 16-bit configuration words; routed address picks one each cycle
// - alu offers inc, dec, add, sub, and, or, xor, pass
// - shift left, shift right or nibble swap, then or-mask, on any alu result
// - two masked comparators over accumulators and data registers
// - zero, all-ones, overflow conditions; selected ones drive route outputs
// - compare 0 conditions combine with neighbour slices via chain signals
// - programmable msb position for arithmetic and shifts
// - one crc/prs step per clock with programmable polynomial
// - wider crc/prs by chaining feedback into adjacent slices
// - two four-byte fifos, each input or output direction
// - fifo status selectable onto route outputs
// - carries, shift data and conditions pass to and from neighbours
// - carry and shift-out registered, selectable as later inputs
// - six routed inputs: config address and serial data
// - each routed output selects a condition or serial output
// - bus-written control bits drive routing connections
// - status register read-only, shows routed signals directly
// - sticky status bits latch events until read, read clears
// - datapath and status/control each have own clock enable
// - byte-wide alu, single-cycle operations
// - accumulators are sources and sinks; data registers only sources
// - fifos load data regs or capture accumulator/alu data
module pbd_datapath #(
  parameter int DW = pbd_pkg::DW,
  parameter int DEPTH = pbd_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration store load port
  input wire logic cfg_we,
  input wire logic [pbd_pkg::CFG_AW-1:0] cfg_waddr,
  input wire logic [pbd_pkg::CFG_W-1:0] cfg_wdata,
  // static setup
  input wire logic [2:0] msb_sel,
  input wire logic [DW-1:0] or_mask,
  input wire logic [DW-1:0] cmp_mask0,
  input wire logic [DW-1:0] cmp_mask1,
  input wire logic cmp1_use_acc1,
  input wire logic [DW-1:0] crc_poly,
  input wire logic or_mask_en,
  input wire logic chain_en,
  input wire logic fifo0_dir_out,
  input wire logic fifo1_dir_out,
  input wire logic [pbd_pkg::COND_SW*pbd_pkg::ROUTE_N-1:0] out_sel,
  input wire logic dp_en,
  input wire logic sc_en,
  // routed inputs: [2:0] config address, [4:3] serial data
  input wire logic [pbd_pkg::ROUTE_N-1:0] route_in,
  // routed outputs
  output logic [pbd_pkg::ROUTE_N-1:0] route_out,
  // chaining
  input wire pbd_pkg::pbd_chain_s chain_in,
  output pbd_pkg::pbd_chain_s chain_out,
  // system bus fifo port, fifo0
  input wire logic bus0_wvalid,
  output logic bus0_wready,
  input wire logic [DW-1:0] bus0_wdata,
  output logic bus0_rvalid,
  input wire logic bus0_rready,
  output logic [DW-1:0] bus0_rdata,
  // system bus fifo port, fifo1
  input wire logic bus1_wvalid,
  output logic bus1_wready,
  input wire logic [DW-1:0] bus1_wdata,
  output logic bus1_rvalid,
  input wire logic bus1_rready,
  output logic [DW-1:0] bus1_rdata,
  // accumulator load from bus
  input wire logic acc_ld0,
  input wire logic acc_ld1,
  input wire logic [DW-1:0] acc_ld_data,
  // status and control
  input wire logic [pbd_pkg::CTRL_W-1:0] ctrl_wdata,
  input wire logic ctrl_we,
  output logic [pbd_pkg::CTRL_W-1:0] ctrl_route,
  input wire logic [pbd_pkg::CTRL_W-1:0] stat_in,
  input wire logic [pbd_pkg::CTRL_W-1:0] stat_sticky,
  input wire logic stat_rd,
  output logic [pbd_pkg::CTRL_W-1:0] stat_rdata,
  // working register view
  output logic [DW-1:0] acc0,
  output logic [DW-1:0] acc1,
  output pbd_pkg::pbd_fstat_s fstat0,
  output pbd_pkg::pbd_fstat_s fstat1
);

  // ---------------------------------------------------------------------
  // configuration store
  // ---------------------------------------------------------------------
  logic [pbd_pkg::CFG_W-1:0] cfg_mem_q [pbd_pkg::CFG_WORDS];
  logic [pbd_pkg::CFG_AW-1:0] addr_q;
  logic [pbd_pkg::CFG_W-1:0] cfg;

  // address registered so the word holds across the whole cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_q <= '0;
    end else if (dp_en) begin
      addr_q <= route_in[pbd_pkg::CFG_AW-1:0];
    end
  end

  // store written by the bus side; contents are not reset
  always_ff @(posedge clk) begin
    if (cfg_we) begin
      cfg_mem_q[cfg_waddr] <= cfg_wdata;
    end
  end

  assign cfg = cfg_mem_q[addr_q];

  // ---------------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------------
  pbd_pkg::pbd_func_e func;
  pbd_pkg::pbd_shift_e shsel;
  logic srca;
  logic [1:0] srcb;
  logic [1:0] cisel;
  logic [1:0] dst;
  logic crc_mode;
  logic d0_ld;
  logic d1_ld;
  logic fwr;

  assign func = pbd_pkg::pbd_func_e'(cfg[pbd_pkg::F_FUNC_LO +: 3]);
  assign srca = cfg[pbd_pkg::F_SRCA];
  assign srcb = cfg[pbd_pkg::F_SRCB_LO +: 2];
  assign shsel = pbd_pkg::pbd_shift_e'(cfg[pbd_pkg::F_SHIFT_LO +: 2]);
  assign cisel = cfg[pbd_pkg::F_CI_LO +: 2];
  assign dst = cfg[pbd_pkg::F_DST_LO +: 2];
  assign crc_mode = cfg[pbd_pkg::F_CRC];
  assign d0_ld = cfg[pbd_pkg::F_D0LD];
  assign d1_ld = cfg[pbd_pkg::F_D1LD];
  assign fwr = cfg[pbd_pkg::F_FWR];

  // ---------------------------------------------------------------------
  // working registers and fifos
  // ---------------------------------------------------------------------
  logic [DW-1:0] acc0_q;
  logic [DW-1:0] acc1_q;
  logic [DW-1:0] d0_q;
  logic [DW-1:0] d1_q;
  logic carry_q;
  logic sout_q;
  logic [DW-1:0] f0_out;
  logic [DW-1:0] f1_out;
  logic f0_ov;
  logic f1_ov;
  logic [DW-1:0] f0_in;
  logic [DW-1:0] f1_in;
  logic f0_iv;
  logic f1_iv;
  logic f0_irdy;
  logic f1_irdy;
  logic f0_ordy;
  logic f1_ordy;
  logic [DW-1:0] res;

  // input direction: bus fills, datapath drains into d regs
  // output direction: datapath fills (fifo0 with results, fifo1 with acc1), bus drains
  assign f0_in = fifo0_dir_out ? res : bus0_wdata;
  assign f1_in = fifo1_dir_out ? acc1_q : bus1_wdata;
  assign f0_iv = fifo0_dir_out ? (fwr && dp_en) : bus0_wvalid;
  assign f1_iv = fifo1_dir_out ? (fwr && dp_en) : bus1_wvalid;
  assign f0_ordy = fifo0_dir_out ? bus0_rready : (d0_ld && dp_en);
  assign f1_ordy = fifo1_dir_out ? bus1_rready : (d1_ld && dp_en);
  assign bus0_wready = !fifo0_dir_out && f0_irdy;
  assign bus1_wready = !fifo1_dir_out && f1_irdy;
  assign bus0_rvalid = fifo0_dir_out && f0_ov;
  assign bus1_rvalid = fifo1_dir_out && f1_ov;
  assign bus0_rdata = f0_out;
  assign bus1_rdata = f1_out;

  pbd_fifo #(.W(DW), .DEPTH(DEPTH)) u_fifo0 (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(f0_iv),
    .in_ready(f0_irdy),
    .in_data(f0_in),
    .out_valid(f0_ov),
    .out_ready(f0_ordy),
    .out_data(f0_out),
    .empty(fstat0.empty),
    .full(fstat0.full)
  );

  pbd_fifo #(.W(DW), .DEPTH(DEPTH)) u_fifo1 (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(f1_iv),
    .in_ready(f1_irdy),
    .in_data(f1_in),
    .out_valid(f1_ov),
    .out_ready(f1_ordy),
    .out_data(f1_out),
    .empty(fstat1.empty),
    .full(fstat1.full)
  );

  // ---------------------------------------------------------------------
  // alu, shifter, mask
  // ---------------------------------------------------------------------
  logic [DW-1:0] opa;
  logic [DW-1:0] opb;
  logic cin;
  logic [DW:0] sum;
  logic [DW-1:0] alu;
  logic [DW-1:0] msbm;
  logic sh_in;
  logic [DW-1:0] shl;
  logic [DW-1:0] shr;
  logic [DW-1:0] shres;
  logic [DW-1:0] crc;
  logic crc_fb;
  logic alu_co;
  logic sh_out;
  logic ovf;

  assign opa = srca ? acc1_q : acc0_q;
  assign opb = (srcb == 2'h0) ? d0_q : (srcb == 2'h1) ? d1_q :
               (srcb == 2'h2) ? acc0_q : acc1_q;
  // carry-in from constant, neighbour or last cycle's carry
  assign cin = (cisel == pbd_pkg::CI_ONE) ? 1'b1 :
               (cisel == pbd_pkg::CI_CHAIN) ? chain_in.carry :
               (cisel == pbd_pkg::CI_REG) ? carry_q : 1'b0;
  // bits above the programmed msb are cleared
  assign msbm = DW'(ONES_FN(msb_sel));

  function automatic logic [DW-1:0] ONES_FN(input logic [2:0] m);
    ONES_FN = pbd_pkg::ONES >> (3'(DW-1) - m);
  endfunction

  // single-cycle byte alu
  always_comb begin
    sum = '0;
    case (func)
      pbd_pkg::PBD_INC: sum = {1'b0, opa} + (DW+1)'(1);
      pbd_pkg::PBD_DEC: sum = {1'b0, opa} - (DW+1)'(1);
      pbd_pkg::PBD_ADD: sum = {1'b0, opa} + {1'b0, opb} + (DW+1)'(cin);
      pbd_pkg::PBD_SUB: sum = {1'b0, opa} - {1'b0, opb} - (DW+1)'(cin);
      pbd_pkg::PBD_AND: sum = {1'b0, opa & opb};
      pbd_pkg::PBD_OR: sum = {1'b0, opa | opb};
      pbd_pkg::PBD_XOR: sum = {1'b0, opa ^ opb};
      default: sum = {1'b0, opa};
    endcase
  end

  assign alu = sum[DW-1:0] & msbm;
  // carry is the bit just above the programmed msb, sum[DW] at full width
  assign alu_co = sum[4'(msb_sel) + 4'h1];
  assign ovf = (opa[msb_sel] == opb[msb_sel]) &&
               (alu[msb_sel] != opa[msb_sel]);
  assign sh_in = (cisel == pbd_pkg::CI_CHAIN) ? chain_in.shift :
                 (cisel == pbd_pkg::CI_REG) ? sout_q : route_in[3];
  assign shl = ((alu << 1) | DW'(sh_in)) & msbm;
  assign shr = (alu >> 1) | (sh_in ? (DW'(1) << msb_sel) : '0);
  assign sh_out = (shsel == pbd_pkg::PBD_SH_LEFT) ? alu[msb_sel] : alu[0];
  // crc/prs: shift left, xor polynomial when feedback set
  assign crc_fb = opa[msb_sel] ^ (chain_en ? chain_in.shift : route_in[4]);
  assign crc = (((opa << 1) & msbm) ^ (crc_fb ? crc_poly : '0)) & msbm;

  // shift stage then optional or mask, independent of alu function
  always_comb begin
    case (shsel)
      pbd_pkg::PBD_SH_LEFT: shres = shl;
      pbd_pkg::PBD_SH_RIGHT: shres = shr;
      pbd_pkg::PBD_SH_SWAP: shres = {alu[3:0], alu[7:4]};
      default: shres = alu;
    endcase
  end

  assign res = crc_mode ? crc :
               (or_mask_en ? (shres | or_mask) : shres);

  // accumulators sink results; data registers only load from fifos
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc0_q <= pbd_pkg::ACC_RST;
      acc1_q <= pbd_pkg::ACC_RST;
      d0_q <= pbd_pkg::ACC_RST;
      d1_q <= pbd_pkg::ACC_RST;
      carry_q <= 1'b0;
      sout_q <= 1'b0;
    end else if (dp_en) begin
      if (acc_ld0) acc0_q <= acc_ld_data;
      else if (dst == 2'h0 || dst == 2'h2) acc0_q <= res;
      if (acc_ld1) acc1_q <= acc_ld_data;
      else if (dst == 2'h1 || dst == 2'h2) acc1_q <= res;
      if (d0_ld && !fifo0_dir_out && f0_ov) d0_q <= f0_out;
      if (d1_ld && !fifo1_dir_out && f1_ov) d1_q <= f1_out;
      carry_q <= alu_co;
      sout_q <= crc_mode ? crc_fb : sh_out;
    end
  end

  assign acc0 = acc0_q;
  assign acc1 = acc1_q;

  // ---------------------------------------------------------------------
  // conditions and routed outputs
  // ---------------------------------------------------------------------
  logic [DW-1:0] c0a;
  logic [DW-1:0] c0b;
  logic [DW-1:0] c1a;
  logic [DW-1:0] c1b;
  logic ce0;
  logic cl0;
  logic ce1;
  logic cl1;
  logic [pbd_pkg::COND_N-1:0] cond;

  // compare 0: acc0 against d0; compare 1: acc0 or acc1 against d1
  assign c0a = acc0_q & cmp_mask0;
  assign c0b = d0_q & cmp_mask0;
  assign c1a = (cmp1_use_acc1 ? acc1_q : acc0_q) & cmp_mask1;
  assign c1b = d1_q & cmp_mask1;
  // compare 0 chains: equal needs neighbour equal, less-than ripples; compare 1 stays local
  assign ce0 = (c0a == c0b) && (!chain_en || chain_in.ce);
  assign cl0 = (c0a < c0b) || (chain_en && c0a == c0b && chain_in.cl);
  assign ce1 = (c1a == c1b);
  assign cl1 = (c1a < c1b);

  assign cond[pbd_pkg::C_CE0] = ce0;
  assign cond[pbd_pkg::C_CL0] = cl0;
  assign cond[pbd_pkg::C_CE1] = ce1;
  assign cond[pbd_pkg::C_CL1] = cl1;
  assign cond[pbd_pkg::C_Z0] = (acc0_q == '0) &&
                               (!chain_en || chain_in.zero);
  assign cond[pbd_pkg::C_Z1] = (acc1_q == '0);
  assign cond[pbd_pkg::C_FF0] = (acc0_q == pbd_pkg::ONES) &&
                                (!chain_en || chain_in.ones);
  assign cond[pbd_pkg::C_FF1] = (acc1_q == pbd_pkg::ONES);
  assign cond[pbd_pkg::C_OV] = ovf;
  assign cond[pbd_pkg::C_SO] = sh_out;
  assign cond[pbd_pkg::C_F0E] = fstat0.empty;
  assign cond[pbd_pkg::C_F0F] = fstat0.full;
  assign cond[pbd_pkg::C_F1E] = fstat1.empty;
  assign cond[pbd_pkg::C_F1F] = fstat1.full;
  assign cond[pbd_pkg::C_CO] = alu_co;
  assign cond[pbd_pkg::C_SOR] = sout_q;

  // chain outputs toward the next slice
  assign chain_out.carry = alu_co;
  assign chain_out.shift = crc_mode ? crc_fb : sh_out;
  assign chain_out.ce = ce0;
  assign chain_out.cl = cl0;
  assign chain_out.zero = cond[pbd_pkg::C_Z0];
  assign chain_out.ones = cond[pbd_pkg::C_FF0];

  // route outputs registered so data outputs come from flip-flops
  logic [pbd_pkg::ROUTE_N-1:0] route_q;
  logic [pbd_pkg::ROUTE_N-1:0] route_d;
  genvar gi;
  for (gi = 0; gi < pbd_pkg::ROUTE_N; gi++) begin : g_route
    assign route_d[gi] = cond[out_sel[gi*pbd_pkg::COND_SW +:
                                      pbd_pkg::COND_SW]];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) route_q <= '0;
    else route_q <= route_d;
  end
  assign route_out = route_q;

  // ---------------------------------------------------------------------
  // status and control
  // ---------------------------------------------------------------------
  logic [pbd_pkg::CTRL_W-1:0] ctrl_q;
  logic [pbd_pkg::CTRL_W-1:0] stick_q;
  logic [pbd_pkg::CTRL_W-1:0] stat_d;

  // sticky bits: a new event in the read cycle survives the clear
  assign stat_d = (stick_q & ~(stat_rd ? stat_sticky : '0)) |
                  (stat_in & stat_sticky);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= '0;
      stick_q <= '0;
    end else if (sc_en) begin
      if (ctrl_we) ctrl_q <= ctrl_wdata;
      stick_q <= stat_d;
    end
  end

  assign ctrl_route = ctrl_q;
  // transparent bits pass live routed state straight to the reader
  assign stat_rdata = (stat_in & ~stat_sticky) |
                      (stick_q & stat_sticky);
endmodule

// *** pbd_assertions.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// port checker for the byte datapath
// ---------------------------------------------------------------------
module pbd_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fifo0 bus side
  input wire logic bus0_wvalid,
  input wire logic bus0_wready,
  input wire logic bus0_rvalid,
  input wire logic fifo0_dir_out,
  input wire pbd_pkg::pbd_fstat_s fstat0,
  // enables and accumulator load
  input wire logic dp_en,
  input wire logic sc_en,
  input wire logic acc_ld0,
  input wire logic [7:0] acc_ld_data,
  input wire logic [7:0] acc0,
  // status and control
  input wire logic ctrl_we,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_route,
  input wire logic [7:0] stat_in,
  input wire logic [7:0] stat_sticky,
  input wire logic stat_rd,
  input wire logic [7:0] stat_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // accepted bus write and a captured status event
  sequence s_push0;
    bus0_wvalid && bus0_wready;
  endsequence
  sequence s_event0;
    sc_en && stat_sticky[0] && stat_in[0];
  endsequence

  // a full or output fifo must refuse, else stored bytes are overwritten
  a_wready_full: assert property (
    bus0_wready == (!fstat0.full && !fifo0_dir_out))
    else $error("write ready disagrees with full or direction");
  a_push_fills: assert property (s_push0 |=> !fstat0.empty)
    else $error("accepted write left fifo empty");
  a_pop_valid: assert property (
    bus0_rvalid |-> (!fstat0.empty && fifo0_dir_out))
    else $error("read valid on empty or input fifo");
  a_ctrl_write: assert property (
    ctrl_we && sc_en |=> ctrl_route == $past(ctrl_wdata))
    else $error("control bits not driven after write");
  a_ctrl_hold: assert property (
    !(ctrl_we && sc_en) |=> $stable(ctrl_route))
    else $error("control bits moved without enabled write");
  a_live_status: assert property (
    !stat_sticky[1] |-> stat_rdata[1] == stat_in[1])
    else $error("live status bit not passed through");
  a_sticky_set: assert property (s_event0 |=> stat_rdata[0])
    else $error("captured event not latched");
  a_sticky_keep: assert property (
    stat_sticky[0] && stat_rdata[0] && !stat_rd |=> stat_rdata[0])
    else $error("latched event lost before read");
  a_sticky_clear: assert property (
    sc_en && stat_rd && stat_sticky[0] && !stat_in[0] ##1 !stat_in[0]
    |-> !stat_rdata[0])
    else $error("read did not clear latched event");
  a_acc_load: assert property (
    acc_ld0 && dp_en |=> acc0 == $past(acc_ld_data))
    else $error("accumulator bus load missed");
  a_acc_idle: assert property (
    !dp_en && !acc_ld0 |=> $stable(acc0))
    else $error("accumulator moved while datapath disabled");
endmodule

bind pbd_datapath pbd_checker u_chk (
  .clk, .rst_n, .bus0_wvalid, .bus0_wready, .bus0_rvalid,
  .fifo0_dir_out, .fstat0, .dp_en, .sc_en, .acc_ld0, .acc_ld_data,
  .acc0, .ctrl_we, .ctrl_wdata, .ctrl_route, .stat_in, .stat_sticky,
  .stat_rd, .stat_rdata
);

// *** pbd_bus_model.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// bus reader draining an output fifo, stalling every other cycle
// ---------------------------------------------------------------------
module pbd_bus_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fifo read side
  input wire logic rvalid,
  input wire logic [7:0] rdata,
  output logic rready,
  // bytes taken, newest in the low byte
  output logic [23:0] got,
  output logic [2:0] cnt
);
  // toggling ready makes the fifo hold its head across stalls
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rready <= 1'b0;
      got <= 24'h000000;
      cnt <= 3'h0;
    end else begin
      rready <= ~rready;
      if (rvalid && rready) begin
        got <= {got[15:0], rdata};
        cnt <= cnt + 3'h1;
      end
    end
  end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  num_errors++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module testbench;
  // ---------------------------------------------------------------------
  // stimulus and observed ports
  // ---------------------------------------------------------------------
  logic clk = 0, rst_n = 0, cfg_we = 0, or_mask_en = 0, dp_en = 1;
  logic sc_en = 1, bus0_wvalid = 0, acc_ld0 = 0, acc_ld1 = 0;
  logic ctrl_we = 0, stat_rd = 0, bus1_rready;
  logic chain_en = 0, cmp1_use_acc1 = 0, fifo0_dir_out = 0;
  logic [7:0] cmp_mask1 = 8'hff, crc_poly = 0;
  logic [2:0] cfg_waddr = 0, msb_sel = 3'h7;
  logic [15:0] cfg_wdata = 0;
  logic [7:0] or_mask = 0, cmp_mask0 = 8'hff, bus0_wdata = 0;
  logic [7:0] acc_ld_data = 0, ctrl_wdata = 0, stat_in = 0;
  logic [7:0] stat_sticky = 0, ctrl_route, stat_rdata, acc0, bus1_rdata;
  logic [5:0] route_in = 0, route_out;
  logic [23:0] got, out_sel = 24'h0000ba;
  logic [2:0] cnt;
  logic [28:0] r;
  logic bus0_wready, bus1_rvalid;
  pbd_pkg::pbd_fstat_s fstat0;
  int num_errors = 0, comparisons = 0, cycles = 0;
  // rows: func, shift, acc0, acc1, expected acc0
  logic [28:0] rows [12] = '{
    {3'd0, 2'd0, 8'hff, 8'h00, 8'h00}, {3'd1, 2'd0, 8'h00, 8'h00, 8'hff},
    {3'd2, 2'd0, 8'h7f, 8'h01, 8'h80}, {3'd3, 2'd0, 8'h10, 8'h01, 8'h0f},
    {3'd4, 2'd0, 8'hf0, 8'h3c, 8'h30}, {3'd5, 2'd0, 8'hf0, 8'h0c, 8'hfc},
    {3'd6, 2'd0, 8'hff, 8'h0f, 8'hf0}, {3'd7, 2'd0, 8'h5a, 8'h00, 8'h5a},
    {3'd7, 2'd1, 8'h81, 8'h00, 8'h02}, {3'd7, 2'd2, 8'h81, 8'h00, 8'h40},
    {3'd7, 2'd3, 8'h12, 8'h00, 8'h21}, {3'd2, 2'd1, 8'h40, 8'h40, 8'h00}};

  always #5 clk = ~clk;

  pbd_datapath dut (
    .clk(clk), .rst_n(rst_n), .cfg_we(cfg_we), .cfg_waddr(cfg_waddr),
    .cfg_wdata(cfg_wdata), .msb_sel(msb_sel), .or_mask(or_mask),
    .cmp_mask0(cmp_mask0), .cmp_mask1(cmp_mask1),
    .cmp1_use_acc1(cmp1_use_acc1),
    .crc_poly(crc_poly), .or_mask_en(or_mask_en), .chain_en(chain_en),
    .fifo0_dir_out(fifo0_dir_out), .fifo1_dir_out(1'b1), .out_sel(out_sel),
    .dp_en(dp_en), .sc_en(sc_en), .route_in(route_in),
    .route_out(route_out), .chain_in('0), .chain_out(),
    .bus0_wvalid(bus0_wvalid), .bus0_wready(bus0_wready),
    .bus0_wdata(bus0_wdata), .bus0_rvalid(), .bus0_rready(1'b0),
    .bus0_rdata(), .bus1_wvalid(1'b0), .bus1_wready(), .bus1_wdata(8'h00),
    .bus1_rvalid(bus1_rvalid), .bus1_rready(bus1_rready),
    .bus1_rdata(bus1_rdata), .acc_ld0(acc_ld0), .acc_ld1(acc_ld1),
    .acc_ld_data(acc_ld_data), .ctrl_wdata(ctrl_wdata), .ctrl_we(ctrl_we),
    .ctrl_route(ctrl_route), .stat_in(stat_in), .stat_sticky(stat_sticky),
    .stat_rd(stat_rd), .stat_rdata(stat_rdata), .acc0(acc0), .acc1(),
    .fstat0(fstat0), .fstat1());

  pbd_bus_model u_bus (.clk(clk), .rst_n(rst_n), .rvalid(bus1_rvalid),
    .rdata(bus1_rdata), .rready(bus1_rready), .got(got), .cnt(cnt));

  // ---------------------------------------------------------------------
  // helpers; every pulse is followed by an idle cycle
  // ---------------------------------------------------------------------
  task cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task wcfg(logic [2:0] a, logic [15:0] w);
    cfg_we = 1; cfg_waddr = a; cfg_wdata = w; cyc(1); cfg_we = 0; cyc(1);
  endtask
  task lda(logic s, logic [7:0] v);
    acc_ld0 = !s; acc_ld1 = s; acc_ld_data = v; cyc(1);
    acc_ld0 = 0; acc_ld1 = 0; cyc(1);
  endtask
  // address taken at one edge, result lands at the next edge
  task run(logic [2:0] a);
    route_in[2:0] = a; cyc(1); route_in[2:0] = 3'h0; cyc(2);
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    // the store is not reset, so the idle word goes in while reset holds
    cyc(3);
    wcfg(3'h0, 16'h0c00);
    `CHK(acc0, 8'h00)
    `CHK(route_out, 6'h00)
    `CHK(ctrl_route, 8'h00)
    `CHK(fstat0, 2'b10)
    rst_n = 1;
    for (int i = 0; i < 12; i++) begin
      r = rows[i];
      wcfg(3'h1, {8'h00, r[25:24], 2'h3, 1'b0, r[28:26]});
      lda(0, r[23:16]);
      lda(1, r[15:8]);
      run(3'h1);
      `CHK(acc0, r[7:0])
    end
    $display("done: alu rows");
    or_mask = 8'h80; or_mask_en = 1;
    wcfg(3'h1, 16'h0037); lda(0, 8'h01); run(3'h1);
    `CHK(acc0, 8'h81)
    or_mask_en = 0; wcfg(3'h1, 16'h0030); dp_en = 0; run(3'h1);
    `CHK(acc0, 8'h81)
    dp_en = 1;
    wcfg(3'h2, 16'h0032); wcfg(3'h3, 16'h0332);
    lda(0, 8'hff); lda(1, 8'h01);
    route_in[2:0] = 3'h2; cyc(1); route_in[2:0] = 3'h3; cyc(1);
    route_in[2:0] = 3'h0; cyc(2);
    `CHK(acc0, 8'h02)
    msb_sel = 3'h3; crc_poly = 8'h03; wcfg(3'h6, 16'h1000);
    lda(0, 8'h09); run(3'h6); msb_sel = 3'h7;
    `CHK(acc0, 8'h01)
    $display("done: mask, enable, carry pair");
    for (int i = 0; i < 5; i++) begin
      bus0_wvalid = 1; bus0_wdata = 8'h11 * (i + 1);
      `CHK(bus0_wready, i < 4)
      cyc(1);
    end
    bus0_wvalid = 0; cyc(1);
    `CHK(fstat0, 2'b01)
    `CHK(route_out[1:0], 2'b10)
    wcfg(3'h4, 16'h2c00);
    repeat (4) run(3'h4);
    cyc(1);
    `CHK(fstat0, 2'b10)
    `CHK(route_out[1:0], 2'b01)
    wcfg(3'h1, 16'h0005); lda(0, 8'h00); run(3'h1);
    `CHK(acc0, 8'h44)
    lda(0, 8'h34); cyc(1);
    `CHK(route_out[2], 1'b0)
    cmp_mask0 = 8'h0f; cyc(2);
    `CHK(route_out[2], 1'b1)
    $display("done: fifo0 fill and drain");
    wcfg(3'h5, 16'h8c00);
    foreach (rows[i]) if (i < 3) begin
      lda(1, 8'ha1 + 8'h11 * i[7:0]); run(3'h5);
    end
    cyc(8);
    `CHK(got, 24'ha1b2c3)
    `CHK(cnt, 3'h3)
    `CHK(fstat0.empty, 1'b1)
    $display("done: output fifo");
    ctrl_wdata = 8'ha5; ctrl_we = 1; cyc(1); ctrl_we = 0;
    `CHK(ctrl_route, 8'ha5)
    sc_en = 0; ctrl_wdata = 8'h5a; cyc(1); ctrl_we = 1; cyc(1); ctrl_we = 0;
    `CHK(ctrl_route, 8'ha5)
    sc_en = 1; stat_sticky = 8'h01; stat_in = 8'h03; #1;
    `CHK(stat_rdata[1], 1'b1)
    cyc(1); stat_in = 8'h00; cyc(1);
    `CHK(stat_rdata[1:0], 2'b01)
    stat_rd = 1; cyc(1); stat_rd = 0; cyc(1);
    `CHK(stat_rdata[0], 1'b0)
    stat_in = 8'h01; cyc(1); stat_rd = 1; cyc(1);
    stat_rd = 0; stat_in = 8'h00;
    `CHK(stat_rdata[0], 1'b1)
    $display("done: status and control");
    conclude();
  end
endmodule
